// ---- ntb_reset_pkg.sv ----
package ntb_reset_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_PS = 40000;
   localparam int PORT_RST_MIN_NS = 250;
   // least time, so round up to whole cycles
   localparam int PORT_RST_CYCLES =
      (PORT_RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PULSE_CNT_W = 4;

   // ==========================================================
   // reset values
   localparam logic RST_OUT_N_INIT = 1'b1;
   localparam logic RST_OE_N_INIT = 1'b1;
   localparam logic FLAG_INIT = 1'b0;

   // ==========================================================
   // encodings
   typedef enum logic [1:0] {
      RA_NONE = 2'b00,
      RA_INT_NOT_READY = 2'b01,
      RA_EXT_NOT_READY = 2'b10,
      RA_BOTH_NOT_READY = 2'b11
   } reset_action_e;

   typedef enum logic [1:0] {
      ROS_NONE = 2'b00,
      ROS_EXT_RESET = 2'b01,
      ROS_RSVD2 = 2'b10,
      ROS_RSVD3 = 2'b11
   } reset_out_sel_e;

   typedef enum logic {
      PC_IDLE = 1'b0,
      PC_PULSE = 1'b1
   } pulse_state_e;

   // ==========================================================
   // configuration carried as one bundle
   typedef struct packed {
      logic ntb_mode;
      logic propagate_ext_fund_reset_int;
      logic propagate_ext_fund_reset_ext;
      logic reset_action_enable;
      reset_action_e reset_action_select;
      reset_out_sel_e bridge_reset_out_select;
      logic irq_enable;
      logic irq_use_msi;
      logic port_c_alt_fn_en;
   } reset_ctrl_s;
endpackage

// ---- ntb_ext_reset.sv ----
// How it works
// - ntb mode plus pin low starts reset
// - propagate bit set escalates to device reset
// - otherwise reset only external side layers
// - local reset spares lock-protected and capability registers
// - reset action enable runs selected action
// - not ready side refuses until configured
// - set opposite reset flag, raise interrupt
// - set opposite fundamental reset seen flag
// - external select pulses port c reset
// - port reset output active low
// - global hot reset releases port reset pins; a still-set alt fn enable retakes them next cycle
// - hot reset ts1 starts internal hot reset
// - dl_down starts internal hot reset
module ntb_ext_reset #(
   parameter int PULSE_CYCLES = ntb_reset_pkg::PORT_RST_CYCLES
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire ntb_reset_pkg::reset_ctrl_s ctrl,
   input wire logic ext_bridge_reset_in_n,
   input wire logic ts1_hot_reset_rx,
   input wire logic dl_down,
   input wire logic int_cfg_done,
   input wire logic ext_cfg_done,
   input wire logic opp_side_reset_seen_clr,
   input wire logic opp_side_fund_reset_seen_clr,
   output logic dev_fund_reset,
   output logic ext_layer_reset,
   output logic ext_reg_init,
   output logic int_side_not_ready,
   output logic ext_side_not_ready,
   output logic opp_side_reset_seen,
   output logic opp_side_fund_reset_seen,
   output logic irq_pulse,
   output logic msi_req,
   output logic int_hot_reset,
   output logic port_c_reset_out_n,
   output logic port_c_reset_oe_n
);
   import ntb_reset_pkg::*;

   localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD =
      PULSE_CNT_W'(PULSE_CYCLES - 1);

   logic pin_low_reg;
   logic hot_src_reg;
   logic dev_fund_reset_reg, dev_fund_reset_next;
   logic ext_layer_reset_reg, ext_layer_reset_next;
   logic ext_reg_init_reg;
   logic int_nr_reg, int_nr_next;
   logic ext_nr_reg, ext_nr_next;
   logic opp_side_reset_seen_reg, opp_side_reset_seen_next;
   logic opp_side_fund_reset_seen_reg, opp_side_fund_reset_seen_next;
   logic irq_reg, msi_reg;
   logic hot_reg;
   logic drive_en_reg, drive_en_next;
   pulse_state_e pc_state_reg, pc_state_next;
   logic [PULSE_CNT_W-1:0] pc_cnt_reg, pc_cnt_next;
   logic rst_out_n_reg, rst_oe_n_reg;

   // ==========================================================
   // event decode
   wire pin_low = ~ext_bridge_reset_in_n;
   wire hot_src = ts1_hot_reset_rx | dl_down;
   wire ext_fund_start = ctrl.ntb_mode & pin_low & ~pin_low_reg;
   wire propagate = ctrl.propagate_ext_fund_reset_int |
                    ctrl.propagate_ext_fund_reset_ext;
   wire local_start = ext_fund_start & ~propagate;
   wire hot_start = hot_src & ~hot_src_reg;
   wire act_int = local_start & ctrl.reset_action_enable &
      (ctrl.reset_action_select == RA_INT_NOT_READY ||
       ctrl.reset_action_select == RA_BOTH_NOT_READY);
   wire act_ext = local_start & ctrl.reset_action_enable &
      (ctrl.reset_action_select == RA_EXT_NOT_READY ||
       ctrl.reset_action_select == RA_BOTH_NOT_READY);
   // only the external selection fires the pulse
   wire pc_fire = ext_fund_start &
      (ctrl.bridge_reset_out_select == ROS_EXT_RESET);

   // ==========================================================
   // reset levels follow the pin while it stays asserted
   // full device reset
   assign dev_fund_reset_next = ctrl.ntb_mode & pin_low &
      (propagate ? (ext_fund_start | dev_fund_reset_reg) :
       dev_fund_reset_reg);
   assign ext_layer_reset_next = ctrl.ntb_mode & pin_low &
      (local_start | ext_layer_reset_reg);

   // ==========================================================
   // not ready: set beats clear so a reset is never missed
   // refuse until configured
   assign int_nr_next = act_int | (int_nr_reg & ~int_cfg_done);
   assign ext_nr_next = act_ext | (ext_nr_reg & ~ext_cfg_done);

   // ==========================================================
   // sticky detection flags, set wins over clear
   // opposite side reset seen
   assign opp_side_reset_seen_next = local_start | (opp_side_reset_seen_reg & ~opp_side_reset_seen_clr);
   assign opp_side_fund_reset_seen_next = local_start |
      (opp_side_fund_reset_seen_reg & ~opp_side_fund_reset_seen_clr);

   // ==========================================================
   // port c pin ownership; hot reset returns it to an input, retaken next cycle if alt fn enable is still set
   // release on global hot reset
   assign drive_en_next = hot_start ? 1'b0 :
      (ctrl.port_c_alt_fn_en | drive_en_reg);

   // ==========================================================
   // pulse machine; hot reset aborts since the pin is released
   // counted low time
   always_comb begin
      pc_state_next = pc_state_reg;
      pc_cnt_next = pc_cnt_reg;
      unique case (pc_state_reg)
         PC_IDLE: begin
            if (pc_fire && !hot_start) begin
               pc_state_next = PC_PULSE;
               pc_cnt_next = PULSE_LOAD;
            end
         end
         PC_PULSE: begin
            if (hot_start) begin
               pc_state_next = PC_IDLE;
               pc_cnt_next = '0;
            end else if (pc_fire) begin
               pc_cnt_next = PULSE_LOAD;
            end else if (pc_cnt_reg == '0) begin
               pc_state_next = PC_IDLE;
            end else begin
               pc_cnt_next = pc_cnt_reg - 1'b1;
            end
         end
      endcase
   end

   // ==========================================================
   // edge history
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_low_reg <= 1'b0;
         hot_src_reg <= 1'b0;
      end else begin
         pin_low_reg <= pin_low;
         hot_src_reg <= hot_src;
      end
   end

   // ==========================================================
   // reset and state flags
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dev_fund_reset_reg <= 1'b0;
         ext_layer_reset_reg <= 1'b0;
         ext_reg_init_reg <= 1'b0;
         int_nr_reg <= FLAG_INIT;
         ext_nr_reg <= FLAG_INIT;
         opp_side_reset_seen_reg <= FLAG_INIT;
         opp_side_fund_reset_seen_reg <= FLAG_INIT;
         hot_reg <= 1'b0;
      end else begin
         dev_fund_reset_reg <= dev_fund_reset_next;
         ext_layer_reset_reg <= ext_layer_reset_next;
         // init strobe; lock-protected fields ignore it
         ext_reg_init_reg <= local_start;
         int_nr_reg <= int_nr_next;
         ext_nr_reg <= ext_nr_next;
         opp_side_reset_seen_reg <= opp_side_reset_seen_next;
         opp_side_fund_reset_seen_reg <= opp_side_fund_reset_seen_next;
         hot_reg <= hot_start;
      end
   end

   // ==========================================================
   // interrupt strobes
   // interrupt or msi when enabled
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         irq_reg <= 1'b0;
         msi_reg <= 1'b0;
      end else begin
         irq_reg <= local_start & ctrl.irq_enable & ~ctrl.irq_use_msi;
         msi_reg <= local_start & ctrl.irq_enable & ctrl.irq_use_msi;
      end
   end

   // ==========================================================
   // port c reset pin, registered so it never glitches
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pc_state_reg <= PC_IDLE;
         pc_cnt_reg <= '0;
         drive_en_reg <= 1'b0;
         rst_out_n_reg <= RST_OUT_N_INIT;
         rst_oe_n_reg <= RST_OE_N_INIT;
      end else begin
         pc_state_reg <= pc_state_next;
         pc_cnt_reg <= pc_cnt_next;
         drive_en_reg <= drive_en_next;
         rst_out_n_reg <= (pc_state_next != PC_PULSE);
         rst_oe_n_reg <= ~(drive_en_next | (pc_state_next == PC_PULSE));
      end
   end

   assign dev_fund_reset = dev_fund_reset_reg;
   assign ext_layer_reset = ext_layer_reset_reg;
   assign ext_reg_init = ext_reg_init_reg;
   assign int_side_not_ready = int_nr_reg;
   assign ext_side_not_ready = ext_nr_reg;
   assign opp_side_reset_seen = opp_side_reset_seen_reg;
   assign opp_side_fund_reset_seen = opp_side_fund_reset_seen_reg;
   assign irq_pulse = irq_reg;
   assign msi_req = msi_reg;
   assign int_hot_reset = hot_reg;
   assign port_c_reset_out_n = rst_out_n_reg;
   assign port_c_reset_oe_n = rst_oe_n_reg;

   // ==========================================================
   // checks
   property p_start_mode;
      @(posedge ref_clk) disable iff (!nrst)
      (ext_layer_reset | dev_fund_reset) |-> $past(ctrl.ntb_mode);
   endproperty
   a_start_mode: assert property (p_start_mode)
      else $error("reset began outside ntb mode");

   property p_escalate;
      @(posedge ref_clk) disable iff (!nrst)
      (ext_fund_start && propagate) |=> dev_fund_reset && !ext_layer_reset;
   endproperty
   a_escalate: assert property (p_escalate)
      else $error("propagated reset did not reset device");

   property p_local;
      @(posedge ref_clk) disable iff (!nrst)
      local_start |=> ext_layer_reset && !dev_fund_reset && ext_reg_init;
   endproperty
   a_local: assert property (p_local)
      else $error("local reset not confined to external side");

   property p_action;
      @(posedge ref_clk) disable iff (!nrst)
      (local_start && !ctrl.reset_action_enable && !int_side_not_ready)
      |=> !int_side_not_ready;
   endproperty
   a_action: assert property (p_action)
      else $error("reset action ran while disabled");

   property p_hold_nr;
      @(posedge ref_clk) disable iff (!nrst)
      (ext_side_not_ready && !ext_cfg_done) |=> ext_side_not_ready;
   endproperty
   a_hold_nr: assert property (p_hold_nr)
      else $error("not ready dropped before configuration");

   property p_flags;
      @(posedge ref_clk) disable iff (!nrst)
      local_start |=> opp_side_reset_seen && opp_side_fund_reset_seen;
   endproperty
   a_flags: assert property (p_flags)
      else $error("detection flags not set");

   property p_irq;
      @(posedge ref_clk) disable iff (!nrst)
      (local_start && ctrl.irq_enable) |=> (irq_pulse ^ msi_req);
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled interrupt not raised");

   property p_width;
      @(posedge ref_clk) disable iff (!nrst || hot_start)
      (pc_fire && !hot_start && port_c_reset_out_n)
      |=> !port_c_reset_out_n [*7];
   endproperty
   a_width: assert property (p_width)
      else $error("port c reset pulse too short");

   property p_release;
      @(posedge ref_clk) disable iff (!nrst)
      hot_start |=> port_c_reset_oe_n && port_c_reset_out_n;
   endproperty
   a_release: assert property (p_release)
      else $error("port c pin driven after hot reset");

   property p_hot;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(hot_src) |=> int_hot_reset;
   endproperty
   a_hot: assert property (p_hot)
      else $error("internal hot reset not started");
endmodule

// ---- root_side_model.sv ----
module root_side_model (
   input wire logic clk,
   output logic pin_n,
   output logic ts1,
   output logic dl_down,
   output logic int_cfg_done,
   output logic ext_cfg_done
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // root complexes and upstream link
   // idle: reset pin released high, link up, no configuring
   initial {pin_n, ts1, dl_down, int_cfg_done, ext_cfg_done} = 5'h10;

   // changes land just after an edge so the block sees them one edge on
   task automatic apply(input logic [4:0] v);
      @(posedge clk);
      {pin_n, ts1, dl_down, int_cfg_done, ext_cfg_done} <= v;
   endtask
endmodule

// ---- ntb_ext_reset_tb_top.sv ----
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module ntb_ext_reset_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ntb_reset_pkg::*;

   // ==========================================================
   // stimulus and wiring
   localparam int PW = 7;
   localparam logic [4:0] IDLE = 5'h10, PIN = 5'h00, TS1 = 5'h18;
   localparam logic [4:0] DL = 5'h14, CFG = 5'h13;
   typedef struct packed {
      reset_ctrl_s c;
      logic [7:0] e;
   } row_s;
   // expect {dev, layer, init, int nr, ext nr, irq, msi, port c out}
   row_s rows [9] = '{19'h60081, 19'h50081, 19'h4ad74, 19'h4c66b,
      19'h4e079, 19'h46061, 19'h48061, 19'h20001, 19'h41061};
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic clr = 1'b0;
   reset_ctrl_s ctrl = '0;
   logic pin_n, ts1, dl_dn, icfg, ecfg;
   logic dev, lay, init, inr, enr, osr, osf, irq, msi, hot, out_n, oe_n;
   int n_errors = 0;
   int cmp_count = 0;
   int i, k;
   // board pull-down takes the pin low once the block lets go
   wire port_c_pin = oe_n ? 1'b0 : out_n;

   always #20 ref_clk = ~ref_clk;

   root_side_model u_root (.clk(ref_clk), .pin_n(pin_n), .ts1(ts1),
      .dl_down(dl_dn), .int_cfg_done(icfg), .ext_cfg_done(ecfg));

   ntb_ext_reset #(.PULSE_CYCLES(PW)) dut (.ref_clk(ref_clk),
      .nrst(nrst), .ctrl(ctrl), .ext_bridge_reset_in_n(pin_n),
      .ts1_hot_reset_rx(ts1), .dl_down(dl_dn), .int_cfg_done(icfg),
      .ext_cfg_done(ecfg), .opp_side_reset_seen_clr(clr),
      .opp_side_fund_reset_seen_clr(clr), .dev_fund_reset(dev),
      .ext_layer_reset(lay), .ext_reg_init(init),
      .int_side_not_ready(inr), .ext_side_not_ready(enr),
      .opp_side_reset_seen(osr), .opp_side_fund_reset_seen(osf),
      .irq_pulse(irq), .msi_req(msi), .int_hot_reset(hot),
      .port_c_reset_out_n(out_n), .port_c_reset_oe_n(oe_n));

   // ==========================================================
   // helpers
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // event taken one edge after the change, answer registered there
   task automatic hit(input logic [4:0] v);
      u_root.apply(v);
      @(posedge ref_clk);
      #1;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      #1;
      `CHK({dev, lay, init, inr, enr, osr, osf, irq, msi, hot}, 10'h0)
      `CHK({out_n, oe_n}, 2'b11)
      @(posedge ref_clk);
      nrst <= 1'b1;
      $display("reset test done");
      // one falling pin per row, then configure, clear and recover
      for (k = 0; k < 9; k++) begin
         @(posedge ref_clk);
         ctrl <= rows[k].c;
         hit(PIN);
         `CHK({dev, lay, init, inr, enr, irq, msi, out_n}, rows[k].e)
         `CHK({osr, osf}, {2{rows[k].e[6]}})
         @(posedge ref_clk);
         #1;
         `CHK({init, irq, msi}, 3'b000)
         `CHK({inr, enr}, rows[k].e[4:3])
         u_root.apply(CFG);
         clr <= 1'b1;
         repeat (9) @(posedge ref_clk);
         clr <= 1'b0;
         u_root.apply(IDLE);
         #1;
         `CHK({dev, lay, inr, enr, osr, osf, out_n}, 7'h01)
      end
      $display("row test done");
      // low time of the port c pulse, counted cycle by cycle
      @(posedge ref_clk);
      ctrl <= 11'h408;
      hit(PIN);
      `CHK({out_n, oe_n}, 2'b00)
      for (i = 0; i < 20 && out_n === 1'b0; i++) begin
         @(posedge ref_clk);
         #1;
      end
      if (i == 20) begin
         n_errors++;
         results();
      end
      `CHK(i, PW)
      `CHK(i * 40 >= 250, 1'b1)
      u_root.apply(IDLE);
      $display("pulse test done");
      // hot reset in mid pulse lets the pin go to the pull-down
      hit(PIN);
      hit(TS1);
      `CHK({hot, out_n, oe_n}, 3'b111)
      `CHK(port_c_pin, 1'b0)
      @(posedge ref_clk);
      #1;
      `CHK(hot, 1'b0)
      // cause must fall first, else no new rising edge
      u_root.apply(IDLE);
      hit(DL);
      `CHK(hot, 1'b1)
      @(posedge ref_clk);
      #1;
      `CHK(hot, 1'b0)
      $display("hot reset test done");
      // reset in mid pulse; pin still low at release is a new event
      u_root.apply(IDLE);
      hit(PIN);
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK({dev, lay, osr, osf, hot, out_n, oe_n}, 7'h03)
      @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      #1;
      `CHK({lay, osr, osf, out_n}, 4'he)
      $display("mid-run reset test done");
      results();
   end
endmodule
